// file: hfc_fan_model.sv
// Fan pin model: tach source with an external pull-up on the pin.
`timescale 1ns/1ps
`default_nettype none
module hfc_fan_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic spin,
	// Pin drive from the block
	input wire logic ctl_out,
	input wire logic ctl_oe,
	// Resolved pin level
	output logic pin_level
);
	logic [1:0] phase_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 2'h0;
		end else if (spin) begin
			phase_reg <= phase_reg + 2'h1;
		end
	end
	// A released pin floats to the pull-up level; a spinning fan pulls
	// it low for half of each revolution slot.
	always_comb begin
		if (ctl_oe) begin
			pin_level = ctl_out;
		end else if (spin) begin
			pin_level = phase_reg[1];
		end else begin
			pin_level = 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: hfc_map.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef HFC_MAP_SVH
`define HFC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define HFC_IDX_DIODE 8'h59
`define HFC_IDX_GAP_A 8'h5a
`define HFC_IDX_FAN45_PIN 8'h5b
`define HFC_IDX_FAN45_DIV 8'h5c
`define HFC_IDX_BATT 8'h5d
`define HFC_IDX_STEP 8'h5e
`define HFC_IDX_GAP_B 8'h5f
`define HFC_IDX_STATUS 8'h60
`define HFC_IDX_MASK 8'h61
`define HFC_IDX_FAN_VALUE 8'h62

// ----------------------------------------------------------------------
// Reset values and writable bit masks
// ----------------------------------------------------------------------
`define HFC_RST_DIODE 8'h70
`define HFC_RST_FAN45_PIN 8'h00
`define HFC_RST_FAN45_DIV 8'h00
`define HFC_RST_BATT 8'h00
`define HFC_RST_STEP 8'h05
`define HFC_WMASK_DIODE 8'h70
`define HFC_WMASK_FAN45_PIN 8'hc0
`define HFC_WMASK_STEP 8'h7f
`define HFC_WMASK_FAN_VALUE 8'h03
`define HFC_WMASK_EVENTS 8'h0f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HFC_BIT_DIODE1 4
`define HFC_BIT_FAN4_TACH 6
`define HFC_BIT_FAN5_TACH 7
`define HFC_BIT_FAN4_PP 3
`define HFC_BIT_FAN5_PP 7
`define HFC_LSB_FAN4_DIV 0
`define HFC_LSB_FAN5_DIV 4
`define HFC_LSB_FAN_MSB 5
`define HFC_BIT_ALARM_EN 4
`define HFC_LSB_BIPOLAR 1
`define HFC_BIT_BATT_EN 0
`define HFC_EV_OVER_TEMP 0
`define HFC_EV_FAN4_TACH 1
`define HFC_EV_FAN5_TACH 2
`define HFC_EV_BATT_READY 3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HFC_CLK_HZ 10000000
`define HFC_BATT_CYCLE_MS 300
`define HFC_BATT_CYCLES ((`HFC_CLK_HZ / 1000) * `HFC_BATT_CYCLE_MS)

`endif

// file: hfc_pkg.sv
// Types shared by the fan and sensor configuration register bank.
package hfc_pkg;

	typedef enum logic [2:0] {
		HFC_BATT_OFF = 3'b001,
		HFC_BATT_SETTLE = 3'b010,
		HFC_BATT_VALID = 3'b100
	} hfc_batt_state_t;

endpackage

// file: hfc_regs.sv
// Fan and temperature sensor configuration registers on an APB port.
`timescale 1ns/1ps
`default_nettype none
`include "hfc_map.svh"

module hfc_regs
	import hfc_pkg::*;
#(
	parameter int BATT_CYCLES = `HFC_BATT_CYCLES
) (
	// Clock and master reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Temperature samples from the measurement engine
	input wire logic [7:0] temperature_in,
	input wire logic temperature_valid,
	// Fan 4 and fan 5 pins
	input wire logic fan4_pin_in,
	output logic fan4_control_out,
	output logic fan4_control_oe,
	input wire logic fan5_pin_in,
	output logic fan5_control_out,
	output logic fan5_control_oe,
	// Divided tach pulses to the speed counters
	output logic fan4_tach_pulse,
	output logic fan5_tach_pulse,
	// Configuration to the measurement engine
	output logic [2:0] diode_cpu_type,
	output logic [2:0] sensor_bipolar_select,
	output logic [2:0] fan123_divisor_msb,
	output logic alarm_response_enable,
	output logic battery_monitor_enable,
	output logic battery_reading_valid,
	// Over-temperature and interrupt
	output logic over_temperature_out_n,
	output logic irq
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Last count of a divide-by-two-to-the-code tach divider.
	function automatic logic [6:0] div_last(input logic [2:0] code);
		logic [7:0] full;
		full = 8'h01 << code;
		return 7'(full - 8'h01);
	endfunction

	// Write a masked byte into a register.
	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [7:0] wdat, input logic [7:0] wmask);
		return (old & ~wmask) | (wdat & wmask);
	endfunction

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic [7:0] diode_reg;
	logic [7:0] pin_reg;
	logic [7:0] div_reg;
	logic [7:0] batt_reg;
	logic [7:0] step_reg;
	logic [7:0] status_reg;
	logic [7:0] mask_reg;
	logic [7:0] value_reg;
	logic [7:0] event_set;
	logic [9:0] idx;
	logic access;
	logic wr;
	logic mapped;
	logic [7:0] rd_next;

	assign idx = paddr[11:2];
	assign access = psel & penable & ~pready;
	assign wr = access & pwrite & pstrb[0];

	always_comb begin
		mapped = 1'b1;
		case (idx)
			{2'b00, `HFC_IDX_DIODE}: rd_next = diode_reg;
			{2'b00, `HFC_IDX_GAP_A}: rd_next = 8'h00;
			{2'b00, `HFC_IDX_FAN45_PIN}: rd_next = pin_reg;
			{2'b00, `HFC_IDX_FAN45_DIV}: rd_next = div_reg;
			{2'b00, `HFC_IDX_BATT}: rd_next = batt_reg;
			{2'b00, `HFC_IDX_STEP}: rd_next = step_reg;
			{2'b00, `HFC_IDX_GAP_B}: rd_next = 8'h00;
			{2'b00, `HFC_IDX_STATUS}: rd_next = status_reg;
			{2'b00, `HFC_IDX_MASK}: rd_next = mask_reg;
			{2'b00, `HFC_IDX_FAN_VALUE}: rd_next = value_reg;
			default: begin
				rd_next = 8'h00;
				mapped = 1'b0;
			end
		endcase
	end

	// One wait state: the answer comes in the second access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			pslverr <= access & ~mapped;
			if (access && (!pwrite || !mapped)) begin
				prdata <= {24'h00_0000, rd_next};
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diode_reg <= `HFC_RST_DIODE;
		end else if (wr && idx == {2'b00, `HFC_IDX_DIODE}) begin
			diode_reg <= merge(diode_reg, pwdata[7:0],
				`HFC_WMASK_DIODE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_reg <= `HFC_RST_FAN45_PIN;
		end else if (wr && idx == {2'b00, `HFC_IDX_FAN45_PIN}) begin
			pin_reg <= merge(pin_reg, pwdata[7:0],
				`HFC_WMASK_FAN45_PIN);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= `HFC_RST_FAN45_DIV;
		end else if (wr && idx == {2'b00, `HFC_IDX_FAN45_DIV}) begin
			div_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			batt_reg <= `HFC_RST_BATT;
		end else if (wr && idx == {2'b00, `HFC_IDX_BATT}) begin
			batt_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_reg <= `HFC_RST_STEP;
		end else if (wr && idx == {2'b00, `HFC_IDX_STEP}) begin
			step_reg <= merge(step_reg, pwdata[7:0],
				`HFC_WMASK_STEP);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= 8'h00;
		end else if (wr && idx == {2'b00, `HFC_IDX_FAN_VALUE}) begin
			value_reg <= merge(value_reg, pwdata[7:0],
				`HFC_WMASK_FAN_VALUE);
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------------

	// A new event wins over a write-one-to-clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 8'h00;
		end else if (wr && idx == {2'b00, `HFC_IDX_STATUS}) begin
			status_reg <= (status_reg & ~pwdata[7:0]) | event_set;
		end else begin
			status_reg <= status_reg | event_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= 8'h00;
		end else if (wr && idx == {2'b00, `HFC_IDX_MASK}) begin
			mask_reg <= merge(mask_reg, pwdata[7:0], `HFC_WMASK_EVENTS);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |((status_reg | event_set) & mask_reg);
		end
	end

	// ------------------------------------------------------------------
	// Configuration outputs
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diode_cpu_type <= 3'b000;
			sensor_bipolar_select <= 3'b000;
			fan123_divisor_msb <= 3'b000;
			alarm_response_enable <= 1'b0;
			battery_monitor_enable <= 1'b0;
		end else begin
			diode_cpu_type <= diode_reg[`HFC_BIT_DIODE1 +: 3];
			sensor_bipolar_select <=
				batt_reg[`HFC_LSB_BIPOLAR +: 3];
			fan123_divisor_msb <= batt_reg[`HFC_LSB_FAN_MSB +: 3];
			alarm_response_enable <= batt_reg[`HFC_BIT_ALARM_EN];
			battery_monitor_enable <= batt_reg[`HFC_BIT_BATT_EN];
		end
	end

	// ------------------------------------------------------------------
	// Fan 4 and fan 5 pins
	// ------------------------------------------------------------------

	// An open-drain pin only ever pulls low; a high level floats.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan4_control_out <= 1'b0;
			fan4_control_oe <= 1'b0;
			fan5_control_out <= 1'b0;
			fan5_control_oe <= 1'b0;
		end else begin
			if (pin_reg[`HFC_BIT_FAN4_TACH]) begin
				fan4_control_out <= 1'b0;
				fan4_control_oe <= 1'b0;
			end else if (div_reg[`HFC_BIT_FAN4_PP]) begin
				fan4_control_out <= value_reg[0];
				fan4_control_oe <= 1'b1;
			end else begin
				fan4_control_out <= 1'b0;
				fan4_control_oe <= ~value_reg[0];
			end
			if (pin_reg[`HFC_BIT_FAN5_TACH]) begin
				fan5_control_out <= 1'b0;
				fan5_control_oe <= 1'b0;
			end else if (div_reg[`HFC_BIT_FAN5_PP]) begin
				fan5_control_out <= value_reg[1];
				fan5_control_oe <= 1'b1;
			end else begin
				fan5_control_out <= 1'b0;
				fan5_control_oe <= ~value_reg[1];
			end
		end
	end

	// ------------------------------------------------------------------
	// Tach dividers
	// ------------------------------------------------------------------
	logic fan4_prev;
	logic fan5_prev;
	logic [6:0] fan4_cnt;
	logic [6:0] fan5_cnt;
	logic fan4_edge;
	logic fan5_edge;
	logic fan4_hit;
	logic fan5_hit;

	assign fan4_edge = fan4_pin_in & ~fan4_prev & pin_reg[`HFC_BIT_FAN4_TACH];
	assign fan5_edge = fan5_pin_in & ~fan5_prev & pin_reg[`HFC_BIT_FAN5_TACH];
	assign fan4_hit = fan4_edge &&
		fan4_cnt >= div_last(div_reg[`HFC_LSB_FAN4_DIV +: 3]);
	assign fan5_hit = fan5_edge &&
		fan5_cnt >= div_last(div_reg[`HFC_LSB_FAN5_DIV +: 3]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan4_prev <= 1'b1;
			fan4_cnt <= 7'h00;
			fan4_tach_pulse <= 1'b0;
		end else begin
			fan4_prev <= fan4_pin_in;
			fan4_tach_pulse <= fan4_hit;
			if (!pin_reg[`HFC_BIT_FAN4_TACH] || fan4_hit) begin
				fan4_cnt <= 7'h00;
			end else if (fan4_edge) begin
				fan4_cnt <= fan4_cnt + 7'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fan5_prev <= 1'b1;
			fan5_cnt <= 7'h00;
			fan5_tach_pulse <= 1'b0;
		end else begin
			fan5_prev <= fan5_pin_in;
			fan5_tach_pulse <= fan5_hit;
			if (!pin_reg[`HFC_BIT_FAN5_TACH] || fan5_hit) begin
				fan5_cnt <= 7'h00;
			end else if (fan5_edge) begin
				fan5_cnt <= fan5_cnt + 7'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// Over-temperature step
	// ------------------------------------------------------------------
	logic step_hit;
	logic [6:0] step_val;

	assign step_val = step_reg[6:0];
	assign step_hit = temperature_valid && step_val != 7'h00 &&
		temperature_in != 8'h00 &&
		(temperature_in % {1'b0, step_val}) == 8'h00;

	// The output holds low until the next sample leaves the multiple.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			over_temperature_out_n <= 1'b1;
		end else if (temperature_valid) begin
			over_temperature_out_n <= ~step_hit;
		end
	end

	// ------------------------------------------------------------------
	// Battery monitor cycle
	// ------------------------------------------------------------------
	hfc_batt_state_t batt_state_reg;
	logic [31:0] batt_cnt_reg;
	logic batt_done;

	assign batt_done = batt_state_reg == HFC_BATT_SETTLE &&
		batt_cnt_reg >= 32'(BATT_CYCLES - 1);

	// Validity is withheld for one full monitor cycle after enabling.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			batt_state_reg <= HFC_BATT_OFF;
			batt_cnt_reg <= 32'h0000_0000;
		end else if (!batt_reg[`HFC_BIT_BATT_EN]) begin
			batt_state_reg <= HFC_BATT_OFF;
			batt_cnt_reg <= 32'h0000_0000;
		end else begin
			case (batt_state_reg)
				HFC_BATT_OFF: begin
					batt_state_reg <= HFC_BATT_SETTLE;
				end
				HFC_BATT_SETTLE: begin
					batt_cnt_reg <= batt_cnt_reg + 32'h0000_0001;
					if (batt_done) begin
						batt_state_reg <= HFC_BATT_VALID;
					end
				end
				HFC_BATT_VALID: begin
					batt_cnt_reg <= 32'h0000_0000;
				end
				default: begin
					batt_state_reg <= HFC_BATT_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			battery_reading_valid <= 1'b0;
		end else begin
			battery_reading_valid <= batt_state_reg == HFC_BATT_VALID &&
				batt_reg[`HFC_BIT_BATT_EN];
		end
	end

	// ------------------------------------------------------------------
	// Events
	// ------------------------------------------------------------------
	always_comb begin
		event_set = 8'h00;
		event_set[`HFC_EV_OVER_TEMP] = step_hit & over_temperature_out_n;
		event_set[`HFC_EV_FAN4_TACH] = fan4_hit;
		event_set[`HFC_EV_FAN5_TACH] = fan5_hit;
		event_set[`HFC_EV_BATT_READY] = batt_done;
	end

endmodule
`default_nettype wire

// file: hfc_regs_checker.sv
// Port-level assertions for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module hfc_regs_checker #(
	parameter int BATT_CYCLES = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic [7:0] temperature_in,
	input wire logic temperature_valid,
	input wire logic fan4_control_oe,
	input wire logic fan4_tach_pulse,
	input wire logic fan5_tach_pulse,
	input wire logic battery_monitor_enable,
	input wire logic battery_reading_valid,
	input wire logic over_temperature_out_n
);
	int en_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_cnt <= 0;
		end else if (!battery_monitor_enable) begin
			en_cnt <= 0;
		end else if (en_cnt < BATT_CYCLES + 8) begin
			en_cnt <= en_cnt + 1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_answer: assert property (
		psel && penable && !pready |=> pready
	) else $error("pready missing after access cycle");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_upper: assert property (
		pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0)
	) else $error("read data upper bits or error data wrong");
	chk_tach_mode: assert property (fan4_tach_pulse |-> !fan4_control_oe)
		else $error("tach pulse while pin drives");
	chk_tach_width: assert property (
		fan5_tach_pulse |=> !fan5_tach_pulse
	) else $error("tach pulse wider than one cycle");
	chk_ovt_hold: assert property (
		!temperature_valid |=> $stable(over_temperature_out_n)
	) else $error("over-temperature moved between samples");
	chk_ovt_zero: assert property (
		temperature_valid && temperature_in == 8'h00 |=> over_temperature_out_n
	) else $error("over-temperature at zero degrees");
	chk_batt_off: assert property (
		!battery_monitor_enable |=> !battery_reading_valid
	) else $error("battery valid while disabled");
	chk_batt_wait: assert property (
		$rose(battery_reading_valid) |-> en_cnt >= BATT_CYCLES
	) else $error("battery valid before monitor cycle");
endmodule
bind hfc_regs hfc_regs_checker #(.BATT_CYCLES(BATT_CYCLES)) checker_inst (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
	.temperature_in, .temperature_valid, .fan4_control_oe,
	.fan4_tach_pulse, .fan5_tach_pulse, .battery_monitor_enable,
	.battery_reading_valid, .over_temperature_out_n
);
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import hfc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, er, spin = 0, temperature_valid = 0;
	logic [7:0] temperature_in = 8'h00;
	logic p4, p5, o4, e4, o5, e5, tp4, tp5, bval, bena, alarm, ovt_n, irq;
	logic [2:0] dct, sbs, fmsb;
	int n_errors = 0, compares = 0, n4, n5, e;
	always #50 pclk = ~pclk;
	hfc_regs #(.BATT_CYCLES(20)) hfc_regs_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
		.pslverr, .temperature_in, .temperature_valid, .fan4_pin_in(p4),
		.fan4_control_out(o4), .fan4_control_oe(e4), .fan5_pin_in(p5),
		.fan5_control_out(o5), .fan5_control_oe(e5), .fan4_tach_pulse(tp4),
		.fan5_tach_pulse(tp5), .diode_cpu_type(dct),
		.sensor_bipolar_select(sbs), .fan123_divisor_msb(fmsb),
		.alarm_response_enable(alarm), .battery_monitor_enable(bena),
		.battery_reading_valid(bval), .over_temperature_out_n(ovt_n),
		.irq);
	hfc_fan_model fan4_inst (.pclk, .presetn, .spin, .ctl_out(o4),
		.ctl_oe(e4), .pin_level(p4));
	hfc_fan_model fan5_inst (.pclk, .presetn, .spin, .ctl_out(o5),
		.ctl_oe(e5), .pin_level(p5));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 4'hf);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] x);
		xfer(1'b0, a, 8'h00, 4'hf);
		chk(rd, {24'h0, x});
	endtask
	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask
	task automatic temp(input logic [7:0] t);
		@(posedge pclk);
		temperature_in <= t;
		temperature_valid <= 1'b1;
		@(posedge pclk);
		temperature_valid <= 1'b0;
		settle();
	endtask
	task automatic stop_test();
		$display("compares %0d, n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge pclk);
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Bank selection is assumed at bank 0 outside this block.
		rdchk(12'h164, 8'h70);
		rdchk(12'h16c, 8'h00);
		rdchk(12'h170, 8'h00);
		rdchk(12'h174, 8'h00);
		rdchk(12'h178, 8'h05);
		chk(dct, 3'b111);
		$display("reset values done");
		wr(12'h164, 8'hff);
		rdchk(12'h164, 8'h70);
		xfer(1'b1, 12'h164, 8'h00, 4'h0);
		rdchk(12'h164, 8'h70);
		wr(12'h164, 8'h20);
		settle();
		chk(dct, 3'b010);
		wr(12'h16c, 8'hff);
		rdchk(12'h16c, 8'hc0);
		wr(12'h178, 8'hff);
		rdchk(12'h178, 8'h7f);
		wr(12'h168, 8'hff);
		rdchk(12'h168, 8'h00);
		wr(12'h17c, 8'hff);
		rdchk(12'h17c, 8'h00);
		rdchk(12'h000, 8'h00);
		chk(er, 1'b1);
		$display("access rules done");
		wr(12'h174, 8'ha5);
		settle();
		chk({fmsb, alarm, sbs, bena}, 8'ha5);
		wr(12'h174, 8'h5a);
		settle();
		chk({fmsb, alarm, sbs, bena}, 8'h5a);
		$display("battery control fields done");
		wr(12'h16c, 8'h00);
		wr(12'h170, 8'h88);
		wr(12'h188, 8'h03);
		settle();
		chk({o5, e5, o4, e4}, 4'hf);
		wr(12'h188, 8'h00);
		settle();
		chk({o5, e5, o4, e4}, 4'h5);
		wr(12'h170, 8'h00);
		settle();
		chk({o5, e5, o4, e4}, 4'h5);
		wr(12'h188, 8'h03);
		settle();
		chk({o5, e5, o4, e4}, 4'h0);
		$display("pin drive done");
		wr(12'h16c, 8'hc0);
		settle();
		chk({e5, e4}, 2'b00);
		for (int c = 0; c < 8; c++) begin
			wr(12'h170, {1'b0, c[2:0], 1'b0, c[2:0]});
			spin <= 1'b1;
			n4 = 0;
			n5 = 0;
			repeat (1024) begin
				@(posedge pclk);
				n4 += (tp4 === 1'b1);
				n5 += (tp5 === 1'b1);
			end
			spin <= 1'b0;
			settle();
			e = 256 >> c;
			if (n4 >= e - 1 && n4 <= e + 1) n4 = e;
			if (n5 >= e - 1 && n5 <= e + 1) n5 = e;
			chk(n4, e);
			chk(n5, e);
		end
		$display("tach divisors done");
		// Software waits a full monitor cycle before trusting the reading.
		wr(12'h174, 8'h01);
		repeat (10) @(posedge pclk);
		#1;
		chk(bval, 1'b0);
		repeat (15) @(posedge pclk);
		#1;
		chk(bval, 1'b1);
		wr(12'h174, 8'h00);
		settle();
		chk(bval, 1'b0);
		$display("battery monitor done");
		// Tach pulses and the finished monitor cycle left their events set.
		rdchk(12'h180, 8'h0e);
		wr(12'h180, 8'h0f);
		wr(12'h178, 8'h05);
		wr(12'h184, 8'h01);
		temp(8'h07);
		chk({ovt_n, irq}, 2'b10);
		temp(8'h0a);
		chk({ovt_n, irq}, 2'b01);
		rdchk(12'h180, 8'h01);
		wr(12'h180, 8'h01);
		settle();
		chk(irq, 1'b0);
		wr(12'h184, 8'h00);
		temp(8'h07);
		temp(8'h0f);
		chk({ovt_n, irq}, 2'b00);
		rdchk(12'h180, 8'h01);
		wr(12'h180, 8'h01);
		wr(12'h178, 8'h00);
		temp(8'h0a);
		chk(ovt_n, 1'b1);
		wr(12'h178, 8'h03);
		temp(8'h09);
		chk(ovt_n, 1'b0);
		temp(8'h0a);
		chk(ovt_n, 1'b1);
		$display("over-temperature and interrupt done");
		stop_test();
	end
endmodule
`default_nettype wire
